// ===== design/jtg_pkg.sv
/*
 * jtg_pkg: constants, instruction codes, state type and pin bundle of the
 * boundary-scan test port.
 * assumes: one system clock that is much faster than the test clock.
 */
`default_nettype none
package jtg_pkg;
    localparam int IR_LEN        = 10;
    localparam int DR32_LEN      = 32;
    localparam int NUM_PINS      = 440;
    localparam int CELLS_PER_PIN = 3;
    localparam int BSR_LEN       = NUM_PINS * CELLS_PER_PIN;
    localparam int CELL_IN       = 0;   // captured pin level
    localparam int CELL_OUT      = 1;   // value to drive
    localparam int CELL_OE       = 2;   // 1 = drive the pin
    localparam int IOCFG_LEN     = 16;  // io element standard select word

    localparam logic [IR_LEN-1:0] IR_SAMPLE   = 10'h005;
    localparam logic [IR_LEN-1:0] IR_EXTEST   = 10'h00f;
    localparam logic [IR_LEN-1:0] IR_BYPASS   = 10'h3ff;
    localparam logic [IR_LEN-1:0] IR_USERCODE = 10'h007;
    localparam logic [IR_LEN-1:0] IR_IDCODE   = 10'h006;
    localparam logic [IR_LEN-1:0] IR_HIGHZ    = 10'h00b;
    localparam logic [IR_LEN-1:0] IR_CLAMP    = 10'h00a;
    localparam logic [IR_LEN-1:0] IR_RECONFIG = 10'h001;
    localparam logic [IR_LEN-1:0] IR_CONFIGIO = 10'h00d;
    localparam logic [IR_LEN-1:0] IR_ICR      = 10'h002;
    localparam logic [IR_LEN-1:0] IR_CAPTURE  = 10'h001;  // fixed 01 in the low bits

    // arbitrary identification value, lsb kept at one
    localparam logic [DR32_LEN-1:0] IDCODE_VAL = 32'h0a5a_5001;

    typedef enum logic [3:0] {
        ST_RESET   = 4'h0, ST_IDLE    = 4'h1, ST_SEL_DR  = 4'h3, ST_CAP_DR  = 4'h2,
        ST_SH_DR   = 4'h6, ST_EX1_DR  = 4'h7, ST_PAU_DR  = 4'h5, ST_EX2_DR  = 4'h4,
        ST_UPD_DR  = 4'hc, ST_SEL_IR  = 4'hd, ST_CAP_IR  = 4'hf, ST_SH_IR   = 4'he,
        ST_EX1_IR  = 4'ha, ST_PAU_IR  = 4'hb, ST_EX2_IR  = 4'h9, ST_UPD_IR  = 4'h8
    } jtg_state_e;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        logic trstN;
    } jtg_pins_s;
endpackage : jtg_pkg
`default_nettype wire

// ===== design/jtg_scan_reg.sv
/*
 * jtg_scan_reg: one capture/shift register of the scan chain, shifting
 * towards bit zero.
 * assumes: capture and shift are one-cycle enables, never both at once;
 * W is two or more, since a one-bit cell is kept as a plain flip-flop.
 */
`default_nettype none
module jtg_scan_reg #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         capEn,
    input  wire logic         shEn,
    input  wire logic [W-1:0] capVal,
    input  wire logic         si,
    output logic      [W-1:0] q,
    output logic              so
);
    // capture loads in parallel, shift moves one place towards the output
    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
        end else if (capEn) begin
            q <= capVal;
        end else if (shEn) begin
            q <= {si, q[W-1:1]};
        end
    end

    assign so = q[0];
endmodule : jtg_scan_reg
`default_nettype wire

// ===== design/jtg_tap.sv
/*
 * jtg_tap: boundary-scan test access port with instruction decode, data
 * register selection, pin override and configuration-control side effects.
 * assumes: test pins arrive asynchronously and are oversampled by clk;
 * configBusy, keeperEn, core pin signals and userCode come from clk logic.
 */
`default_nettype none
module jtg_tap
    import jtg_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire jtg_pins_s            tapPins,
    output logic                      tdo,
    output logic                      tdoOeN,
    input  wire logic [NUM_PINS-1:0]  pinIn,
    input  wire logic [NUM_PINS-1:0]  coreOut,
    input  wire logic [NUM_PINS-1:0]  coreOeN,
    output logic      [NUM_PINS-1:0]  pinOut,
    output logic      [NUM_PINS-1:0]  pinOeN,
    input  wire logic [NUM_PINS-1:0]  keeperEn,
    output logic      [NUM_PINS-1:0]  pinKeep,
    input  wire logic                 configBusy,
    input  wire logic [DR32_LEN-1:0]  userCode,
    output logic                      reconfigReqN,
    output logic                      statusOut,
    output logic                      statusOeN,
    output logic                      configStop,
    output logic      [IOCFG_LEN-1:0] ioStdCfg,
    output logic      [DR32_LEN-1:0]  icrWord,
    output logic                      icrStrobe
);
    jtg_pins_s             s1, s2, s3;
    logic [NUM_PINS-1:0]   p1, p2, p3;
    jtg_state_e            state, next_state;
    logic [IR_LEN-1:0]     instr;
    logic                  bypassBit;
    logic [BSR_LEN-1:0]    bsrQ, bsrUpd, bsrCap;
    logic [IR_LEN-1:0]     irQ;
    logic [DR32_LEN-1:0]   d32Q, icrQ;
    logic [IOCFG_LEN-1:0]  iocQ;
    logic                  irSo, bsrSo, d32So, icrSo, iocSo;
    logic                  cfgHold;

    // three-stage sampling of the test pins and user pins
    always_ff @(posedge clk) begin
        if (rst) begin
            s1 <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b1, trstN: 1'b1};
            s2 <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b1, trstN: 1'b1};
            s3 <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b1, trstN: 1'b1};
            p1 <= '0;
            p2 <= '0;
            p3 <= '0;
        end else begin
            s1 <= tapPins;
            s2 <= s1;
            s3 <= s2;
            p1 <= pinIn;
            p2 <= p1;
            p3 <= p2;
        end
    end

    // edges count when the second stage holds a new level and the third still holds the old one
    wire tckRise  = s2.tck & ~s3.tck;
    wire tckFall  = ~s2.tck & s3.tck;
    wire trstLow  = ~s2.trstN & ~s3.trstN;
    wire tmsV     = s3.tms;
    wire tdiV     = s3.tdi;

    // controller next state; tms sampled on rising test clock
    always_comb begin
        next_state = state;
        case (state)
            ST_RESET:  next_state = tmsV ? ST_RESET  : ST_IDLE;
            ST_IDLE:   next_state = tmsV ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: next_state = tmsV ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: next_state = tmsV ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR:  next_state = tmsV ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: next_state = tmsV ? ST_UPD_DR : ST_PAU_DR;
            ST_PAU_DR: next_state = tmsV ? ST_EX2_DR : ST_PAU_DR;
            ST_EX2_DR: next_state = tmsV ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: next_state = tmsV ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: next_state = tmsV ? ST_RESET  : ST_CAP_IR;
            ST_CAP_IR: next_state = tmsV ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR:  next_state = tmsV ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: next_state = tmsV ? ST_UPD_IR : ST_PAU_IR;
            ST_PAU_IR: next_state = tmsV ? ST_EX2_IR : ST_PAU_IR;
            ST_EX2_IR: next_state = tmsV ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: next_state = tmsV ? ST_SEL_DR : ST_IDLE;
            default:   next_state = ST_RESET;
        endcase
    end

    // test reset overrides the clock so a stalled test clock cannot block it
    always_ff @(posedge clk) begin
        if (rst || trstLow) begin
            state <= ST_RESET;
        end else if (tckRise) begin
            state <= next_state;
        end
    end

    // per-state one-cycle strobes, all taken on the rising test clock
    wire capIr = tckRise && state == ST_CAP_IR;
    wire shIr  = tckRise && state == ST_SH_IR;
    wire updIr = tckRise && state == ST_UPD_IR;
    wire capDr = tckRise && state == ST_CAP_DR;
    wire shDr  = tckRise && state == ST_SH_DR;
    wire updDr = tckRise && state == ST_UPD_DR;

    // instruction decode; anything unlisted falls through to bypass
    wire isSample = instr == IR_SAMPLE;
    wire isExtest = instr == IR_EXTEST;
    wire isUser   = instr == IR_USERCODE;
    wire isId     = instr == IR_IDCODE;
    wire isHighz  = instr == IR_HIGHZ;
    wire isClamp  = instr == IR_CLAMP;
    wire isCfgIo  = instr == IR_CONFIGIO;
    wire isIcr    = instr == IR_ICR;
    wire selBsr   = isSample | isExtest;
    wire selD32   = isUser | isId;
    wire selByp   = ~(selBsr | selD32 | isCfgIo | isIcr);

    // active instruction; reset state loads identification as the default
    always_ff @(posedge clk) begin
        if (rst || state == ST_RESET) begin
            instr <= IR_IDCODE;
        end else if (updIr) begin
            instr <= irQ;
        end
    end

    // instruction shift register, captures the fixed 01 pattern
    jtg_scan_reg #(.W(IR_LEN)) irReg (
        .clk(clk), .rst(rst), .capEn(capIr), .shEn(shIr),
        .capVal(IR_CAPTURE), .si(tdiV), .q(irQ), .so(irSo)
    );

    // boundary cells: capture pin level, core output and core enable
    for (genvar i = 0; i < NUM_PINS; i++) begin : gCell
        assign bsrCap[i*CELLS_PER_PIN+CELL_IN]  = p3[i];
        assign bsrCap[i*CELLS_PER_PIN+CELL_OUT] = coreOut[i];
        assign bsrCap[i*CELLS_PER_PIN+CELL_OE]  = ~coreOeN[i];
    end

    jtg_scan_reg #(.W(BSR_LEN)) bsrReg (
        .clk(clk), .rst(rst), .capEn(capDr & selBsr), .shEn(shDr & selBsr),
        .capVal(bsrCap), .si(tdiV), .q(bsrQ), .so(bsrSo)
    );

    // 32-bit register serves both identification and user code
    jtg_scan_reg #(.W(DR32_LEN)) d32Reg (
        .clk(clk), .rst(rst), .capEn(capDr & selD32), .shEn(shDr & selD32),
        .capVal(isUser ? userCode : IDCODE_VAL),
        .si(tdiV), .q(d32Q), .so(d32So)
    );

    // in-circuit reconfiguration words handed to the configuration logic
    jtg_scan_reg #(.W(DR32_LEN)) icrReg (
        .clk(clk), .rst(rst), .capEn(capDr & isIcr), .shEn(shDr & isIcr),
        .capVal(icrWord), .si(tdiV), .q(icrQ), .so(icrSo)
    );

    // io element standard register, captures the current setting
    jtg_scan_reg #(.W(IOCFG_LEN)) iocReg (
        .clk(clk), .rst(rst), .capEn(capDr & isCfgIo), .shEn(shDr & isCfgIo),
        .capVal(ioStdCfg), .si(tdiV), .q(iocQ), .so(iocSo)
    );

    // bypass cell captures zero as the standard requires
    always_ff @(posedge clk) begin
        if (rst || (capDr && selByp)) begin
            bypassBit <= 1'b0;
        end else if (shDr && selByp) begin
            bypassBit <= tdiV;
        end
    end

    // update latches: preload pattern, io standards, icr word
    always_ff @(posedge clk) begin
        if (rst) begin
            bsrUpd    <= '0;
            ioStdCfg  <= '0;
            icrWord   <= '0;
            icrStrobe <= 1'b0;
        end else begin
            icrStrobe <= updDr & isIcr;
            if (updDr && selBsr) bsrUpd <= bsrQ;
            if (updDr && isCfgIo) ioStdCfg <= iocQ;
            if (updDr && isIcr) icrWord <= icrQ;
        end
    end

    // status hold: set by loading the io config code, freed at update-dr;
    // the set side wins if both fall in one cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            cfgHold <= 1'b0;
        end else if (updIr && irQ == IR_CONFIGIO) begin
            cfgHold <= 1'b1;
        end else if (updDr && isCfgIo) begin
            cfgHold <= 1'b0;
        end
    end

    // status pin is open drain: only ever pulled low
    assign statusOut  = 1'b0;
    assign statusOeN  = ~cfgHold;
    assign configStop = isCfgIo & configBusy;

    // reconfig request is a one-cycle low pulse; the real pin is untouched
    always_ff @(posedge clk) begin
        if (rst) begin
            reconfigReqN <= 1'b1;
        end else begin
            reconfigReqN <= ~(updIr && irQ == IR_RECONFIG);
        end
    end

    // pin overrides are held off while configuration runs
    wire testDrive = (isExtest | isClamp) & ~configBusy;
    wire testFloat = isHighz & ~configBusy;
    for (genvar i = 0; i < NUM_PINS; i++) begin : gPin
        wire cellOe  = bsrUpd[i*CELLS_PER_PIN+CELL_OE];
        wire floatIt = testFloat | (testDrive & ~cellOe);
        assign pinOut[i]  = testDrive ? bsrUpd[i*CELLS_PER_PIN+CELL_OUT] : coreOut[i];
        assign pinOeN[i]  = testFloat ? 1'b1 : (testDrive ? ~cellOe : coreOeN[i]);
        assign pinKeep[i] = floatIt & keeperEn[i];
    end

    // selected serial output
    wire drSo = selBsr ? bsrSo : selD32 ? d32So : isIcr ? icrSo : isCfgIo ? iocSo : bypassBit;
    wire inShift = state == ST_SH_DR || state == ST_SH_IR;

    // tdo moves only on the falling test clock, so the far end samples it
    // on the rising edge with half a test period of margin
    always_ff @(posedge clk) begin
        if (rst) begin
            tdo    <= 1'b1;
            tdoOeN <= 1'b1;
        end else if (tckFall) begin
            tdoOeN <= ~inShift;
            // outside a shift state the line is released, so tdo keeps its last bit
            if (inShift) tdo <= (state == ST_SH_IR) ? irSo : drSo;
        end
    end
endmodule : jtg_tap
`default_nettype wire

// ===== testbench/jtg_tap_props.sv
/* jtg_tap_props: timing and side-output checks on the test port.
   assumes: bound into jtg_tap; tck is a plain input sampled by clk. */
`default_nettype none
module jtg_tap_props
    import jtg_pkg::*;
(
    input wire logic                clk,
    input wire logic                rst,
    input wire jtg_pins_s           tapPins,
    input wire logic                tdo,
    input wire logic                tdoOeN,
    input wire logic [NUM_PINS-1:0] pinOut,
    input wire logic [NUM_PINS-1:0] pinOeN,
    input wire logic [NUM_PINS-1:0] coreOut,
    input wire logic [NUM_PINS-1:0] coreOeN,
    input wire logic [NUM_PINS-1:0] keeperEn,
    input wire logic [NUM_PINS-1:0] pinKeep,
    input wire logic                configBusy,
    input wire logic                reconfigReqN,
    input wire logic                statusOeN,
    input wire logic                configStop,
    input wire logic                icrStrobe
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic       prevTck;
    logic [3:0] sinceFall;
    // clk edges since the tck pin fell; judged on the pin, not on the design's own sync
    always_ff @(posedge clk) begin
        prevTck <= tapPins.tck;
        if (rst) sinceFall <= 4'hf;
        else if (prevTck && !tapPins.tck) sinceFall <= 4'h1;
        else if (sinceFall != 4'hf) sinceFall <= sinceFall + 4'h1;
    end
    sequence lowOnce;
        !reconfigReqN ##1 reconfigReqN;
    endsequence
    tdo_after_fall_a: assert property ($changed(tdo) |-> sinceFall inside {[2:6]})
        else $error("tdo moved away from a tck fall");
    oe_after_fall_a: assert property ($changed(tdoOeN) |-> sinceFall inside {[2:6]})
        else $error("tdo enable moved away from a tck fall");
    reconfig_pulse_a: assert property ($fell(reconfigReqN) |-> lowOnce)
        else $error("reconfig request not a one-cycle low");
    icr_strobe_a: assert property ($rose(icrStrobe) |=> !icrStrobe)
        else $error("reconfig word strobe longer than one cycle");
    stop_busy_a: assert property (configStop |-> configBusy)
        else $error("configuration halt without configuration running");
    busy_pins_a: assert property (configBusy |-> pinOeN == coreOeN && pinOut == coreOut)
        else $error("pin test override during configuration");
    keep_float_a: assert property ((pinKeep & ~(keeperEn & pinOeN)) == '0)
        else $error("keeper flag on a driven or keeperless pin");
    reset_vals_a: assert property ($fell(rst) |-> tdo && tdoOeN && reconfigReqN && statusOeN)
        else $error("outputs not at reset values");
endmodule : jtg_tap_props
bind jtg_tap jtg_tap_props u_props (.clk(clk), .rst(rst), .tapPins(tapPins), .tdo(tdo),
    .tdoOeN(tdoOeN), .pinOut(pinOut), .pinOeN(pinOeN), .coreOut(coreOut), .coreOeN(coreOeN),
    .keeperEn(keeperEn), .pinKeep(pinKeep), .configBusy(configBusy), .reconfigReqN(reconfigReqN),
    .statusOeN(statusOeN), .configStop(configStop), .icrStrobe(icrStrobe));
`default_nettype wire

// ===== testbench/jtg_host_model.sv
/* jtg_host_model: external test host walking the port controller.
   assumes: clk is far faster than tck; tdo has settled by the tck rise. */
`default_nettype none
module jtg_host_model
    import jtg_pkg::*;
(
    input  wire logic clk,
    output var jtg_pins_s tapPins,
    input  wire logic tdo
);
    timeunit 1ns;
    timeprecision 1ns;
    int halfClk = 4; // tck half period in clk cycles; raise it for a slow host
    initial tapPins = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1, trstN: 1'b1};
    // one tck period; tms and tdi move at the fall so they are long settled at the rise
    task automatic step(input logic ms, input logic di, output logic dq);
        tapPins.tms <= ms;
        tapPins.tdi <= di;
        repeat (halfClk) @(posedge clk);
        dq = tdo;
        tapPins.tck <= 1'b1;
        repeat (halfClk) @(posedge clk);
        tapPins.tck <= 1'b0;
    endtask : step
    // idle, one scan lsb first, back to idle with one spare idle clock
    task automatic scan(input logic isIr, input int n, input logic [BSR_LEN-1:0] din,
                        output logic [BSR_LEN-1:0] dout);
        logic q;
        dout = '0;
        step(1'b1, 1'b0, q);
        if (isIr) step(1'b1, 1'b1, q);
        step(1'b0, 1'b0, q);
        step(1'b0, 1'b1, q);
        for (int i = 0; i < n; i++) begin
            step(1'(i == n - 1), din[i], dout[i]);
        end
        step(1'b1, 1'b0, q);
        step(1'b0, 1'b1, q);
        step(1'b0, 1'b0, q);
    endtask : scan
    // test reset pulse, then five tms-high clocks anyway, then idle
    task automatic home();
        logic q;
        tapPins.trstN <= 1'b0;
        repeat (8) @(posedge clk);
        tapPins.trstN <= 1'b1;
        repeat (5) step(1'b1, 1'b0, q);
        step(1'b0, 1'b1, q);
    endtask : home
endmodule : jtg_host_model
`default_nettype wire

// ===== testbench/tb_top.sv
/* tb_top: scenario bench for the boundary-scan test port.
   assumes: jtg_host_model plays the host; core, pin and config inputs are driven here. */
`default_nettype none
module tb_top
    import jtg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic configBusy = 1'b0;
    logic [NUM_PINS-1:0] pinIn = {220{2'b10}}, coreOut = '0, coreOeN = '1, keeperEn = {220{2'b01}};
    logic [NUM_PINS-1:0] pinOut, pinOeN, pinKeep;
    logic [DR32_LEN-1:0] userCode = '0, icrWord;
    logic [IOCFG_LEN-1:0] ioStdCfg;
    logic tdo, tdoOeN, statusOut, reconfigReqN, statusOeN, configStop, icrStrobe;
    logic [BSR_LEN-1:0] dq;
    jtg_pins_s tapPins;
    int n_errors = 0, n_checks = 0, nPulse = 0, nStrobe = 0, cyc = 0;
    jtg_host_model host (.clk(clk), .tapPins(tapPins), .tdo(tdo));
    jtg_tap uut (.clk(clk), .rst(rst), .tapPins(tapPins), .tdo(tdo), .tdoOeN(tdoOeN), .pinIn(pinIn),
        .coreOut(coreOut), .coreOeN(coreOeN), .pinOut(pinOut), .pinOeN(pinOeN), .keeperEn(keeperEn),
        .pinKeep(pinKeep), .configBusy(configBusy), .userCode(userCode), .reconfigReqN(reconfigReqN),
        .statusOut(statusOut), .statusOeN(statusOeN), .configStop(configStop), .ioStdCfg(ioStdCfg),
        .icrWord(icrWord), .icrStrobe(icrStrobe));
    initial forever #50 clk = ~clk;
    // pulse counters and hang guard; a hang still ends in the one closing report
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (!reconfigReqN) nPulse <= nPulse + 1;
        if (icrStrobe) nStrobe <= nStrobe + 1;
        if (cyc == 60000) begin
            n_errors = n_errors + 1;
            end_of_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic ir(input logic [IR_LEN-1:0] code);
        host.scan(1'b1, IR_LEN, BSR_LEN'(code), dq);
    endtask : ir
    task automatic dr(input int n, input logic [BSR_LEN-1:0] din);
        host.scan(1'b0, n, din, dq);
    endtask : dr
    // captured input cells must mirror every pin
    task automatic cap_chk();
        int bad = 0;
        for (int i = 0; i < NUM_PINS; i++) bad += int'(dq[3*i] !== pinIn[i]);
        chk(32'(bad), 32'h0);
    endtask : cap_chk
    task automatic t_ident();
        ir(IR_IDCODE);
        chk(32'(dq[IR_LEN-1:0]), 32'(IR_CAPTURE));
        dr(DR32_LEN, '0);
        chk(dq[31:0], IDCODE_VAL);
        chk(32'(tdoOeN), 32'h1);
    endtask : t_ident
    // every one-bit path code but reconfig, plus one unlisted, delays tdi by one with a 0 in front
    task automatic t_bypass();
        logic [IR_LEN-1:0] codes [4] = '{IR_BYPASS, IR_HIGHZ, IR_CLAMP, 10'h155};
        foreach (codes[k]) begin
            ir(codes[k]);
            dr(8, BSR_LEN'(8'ha5));
            chk(32'(dq[7:0]), 32'h4a);
        end
    endtask : t_bypass
    // slow host here: tck half period of six clk
    task automatic t_user();
        userCode <= 32'hc3a5_0f96;
        host.halfClk = 6;
        ir(IR_USERCODE);
        dr(DR32_LEN, '0);
        chk(dq[31:0], 32'hc3a5_0f96);
        host.halfClk = 4;
    endtask : t_user
    task automatic t_pins();
        logic [BSR_LEN-1:0] pat = '0;
        pat[2:1] = 2'b11;
        pat[3*439+2] = 1'b1;
        ir(IR_SAMPLE);
        dr(BSR_LEN, pat);
        cap_chk();
        ir(IR_EXTEST);
        chk({30'h0, pinOut[0], pinOeN[0]}, 32'h2);
        chk({30'h0, pinOut[439], pinOeN[439], pinOeN[1]}, 32'h1);
        pinIn <= ~pinIn;
        dr(BSR_LEN, pat);
        cap_chk();
        configBusy <= 1'b1;
        repeat (3) @(posedge clk);
        chk(32'(pinOeN[439]), 32'h1);
        configBusy <= 1'b0;
        // clamp keeps the scanned levels on the pins
        ir(IR_CLAMP);
        chk({30'h0, pinOut[0], pinOeN[0]}, 32'h2);
        ir(IR_HIGHZ);
        chk({31'h0, &pinOeN}, 32'h1);
        chk(32'(pinKeep[15:0]), 32'h5555);
    endtask : t_pins
    task automatic t_side();
        int p0 = nPulse;
        int s0 = nStrobe;
        ir(IR_RECONFIG);
        chk(32'(nPulse - p0), 32'h1);
        ir(IR_ICR);
        dr(DR32_LEN, BSR_LEN'(32'h1234_abcd));
        chk(icrWord, 32'h1234_abcd);
        chk(32'(nStrobe - s0), 32'h1);
    endtask : t_side
    task automatic t_cfgio();
        configBusy <= 1'b1;
        ir(IR_CONFIGIO);
        chk({30'h0, configStop, statusOeN}, 32'h2);
        chk(32'(statusOut), 32'h0);
        dr(IOCFG_LEN, BSR_LEN'(16'h5a3c));
        chk(32'(dq[15:0]), 32'h0);
        chk({16'h0, ioStdCfg}, 32'h5a3c);
        chk(32'(statusOeN), 32'h1);
        configBusy <= 1'b0;
    endtask : t_cfgio
    // test reset in mid-shift must drop the scan and restore the id path
    task automatic t_trst();
        logic q;
        ir(IR_USERCODE);
        host.step(1'b1, 1'b0, q);
        host.step(1'b0, 1'b0, q);
        host.step(1'b0, 1'b0, q);
        // the fall inside shift-dr has turned the tdo driver on
        repeat (4) @(posedge clk);
        chk(32'(tdoOeN), 32'h0);
        host.home();
        dr(DR32_LEN, '0);
        chk(dq[31:0], IDCODE_VAL);
    endtask : t_trst
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_of_test
    // scans only while configuration is idle, apart from the deliberate busy cases
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        host.home();
        t_ident();
        t_bypass();
        t_user();
        t_pins();
        t_side();
        t_cfgio();
        t_trst();
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
